/* File: eis_pkg.sv */
// eis_pkg: shared types, register indices, field positions and reset values
// of the external interrupt front end.
// assumes a 32-bit APB slave; each byte register sits alone in one aligned word.
package eis_pkg;

  // apb request bundle from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } eis_apb_req_t;

  // apb answer bundle to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } eis_apb_rsp_t;

  // core acceptance side
  typedef struct packed {
    logic iflag;       // global interrupt enable flag
    logic [2:0] processor_priority_level;   // processor_priority_level
    logic accept;      // one-cycle pulse: offered request taken
  } eis_cpu_t;

  // instruction events from the core
  typedef struct packed {
    logic undefined_opcode_instr;
    logic break_instr;
    logic overflow_trap_instr;
    logic overflow_flag;
    logic int_instr;
    logic [5:0] int_num;
  } eis_instr_t;

  // software interrupt kinds reported to the core
  typedef enum logic [2:0] {
    SW_NONE = 3'b000,
    SW_UND = 3'b001,
    SW_OVF = 3'b010,
    SW_BRK = 3'b011,
    SW_INT = 3'b100
  } eis_sw_kind_t;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_MODE = 10'h01E;
  localparam logic [9:0] IDX_SEL_THIRD = 10'h205;
  localparam logic [9:0] IDX_SEL_SECOND = 10'h206;
  localparam logic [9:0] IDX_SEL_PRIMARY = 10'h207;
  localparam logic [9:0] IDX_AM_EN_A = 10'h20E;
  localparam logic [9:0] IDX_AM_EN_B = 10'h20F;
  localparam logic [9:0] IDX_AM_TARGET0 = 10'h210;
  localparam logic [9:0] IDX_PORT_CTRL = 10'h366;
  localparam logic [9:0] IDX_NMI_FILTER = 10'h369;
  // control register index per external input 0..7
  localparam logic [9:0] IDX_EXT_CTRL [8] = '{10'h05D, 10'h05E, 10'h05F, 10'h044,
                                              10'h049, 10'h048, 10'h043, 10'h042};

  // control register fields
  localparam int LVL_MSB = 2;
  localparam int FLAG_BIT = 3;
  localparam int POL_BIT = 4;
  localparam int RSV_BIT = 5;
  // primary select fields
  localparam int SHARED_A_BIT = 6;
  localparam int SHARED_B_BIT = 7;
  // mode / port control fields
  localparam int NMI_EN_BIT = 4;
  localparam int IN6_BLOCK_BIT = 5;
  localparam int IN7_BLOCK_BIT = 6;
  localparam int KEY_BLOCK_BIT = 7;
  // software interrupt number split for stack select
  localparam logic [5:0] INT_NUM_STACK_LIMIT = 6'h20;
  // widths and reset values
  localparam int N_EXT = 8;
  localparam int N_SHARED = 10;
  localparam int N_AM = 4;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [19:0] AM_TARGET_RESET = 20'h0_0000;

endpackage : eis_pkg

/* File: eis_edge.sv */
// eis_edge: two-flop synchroniser and edge detector for a group of pins.
// assumes pins may change at any time relative to the clock.
`timescale 1ns/100ps
module eis_edge #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // pins
  input wire logic [W-1:0] pin_i,
  // detected edges as one-cycle pulses, and the synced level
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o,
  output logic [W-1:0] level_o
);
  // all state: first stage, second stage, previous synced value
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] prev;
  } eis_edge_st_t;

  eis_edge_st_t st;
  eis_edge_st_t next_st;

  // shift pins through; first stage feeds only the second
  always_comb begin
    next_st = st;
    next_st.s1 = pin_i;
    next_st.s2 = st.s1;
    next_st.prev = st.s2;
  end

  // register state; pins idle high after reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  // edges from synced stage against its previous value
  assign rise_o = st.s2 & ~st.prev;
  assign fall_o = ~st.s2 & st.prev;
  assign level_o = st.s2;
endmodule : eis_edge

/* File: eis_ctrl.sv */
// eis_ctrl: one interrupt control register with priority, request flag,
// polarity and reserved bit.
// assumes write strobes and set/accept pulses last one cycle.
`timescale 1ns/100ps
module eis_ctrl (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // software write
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  // hardware events
  input wire logic set_i,
  input wire logic accept_i,
  // register contents
  output logic [7:0] value_o
);
  import eis_pkg::*;

  // all state of the register
  typedef struct packed {
    logic rsv;
    logic edge_polarity;
    logic request_flag;
    logic [2:0] priority_level;
  } eis_ctrl_st_t;

  eis_ctrl_st_t st;
  eis_ctrl_st_t next_st;

  // writes update fields; flag may only be cleared, and a set wins
  always_comb begin
    next_st = st;
    if (wr_i) begin
      next_st.priority_level = wdata_i[LVL_MSB:0];
      next_st.edge_polarity = wdata_i[POL_BIT];
      next_st.rsv = wdata_i[RSV_BIT];
    end
    // clear by a written 0 or by acceptance, set by a request
    next_st.request_flag = set_i |
                           (st.request_flag & ~(wr_i & ~wdata_i[FLAG_BIT]) & ~accept_i);
  end

  // register state
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // unimplemented top bits read as zero
  assign value_o = {2'b00, st.rsv, st.edge_polarity, st.request_flag, st.priority_level};
endmodule : eis_ctrl

/* File: eis_top.sv */
// eis_top: external interrupt front end with apb registers, edge detection,
// source selection, maskable request offer and special interrupt strobes.
// assumes all inputs are synchronous to SYS_CLK_I except the pins that go
// through the synchroniser; the core pulses accept for one cycle.
`timescale 1ns/100ps
module eis_top (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  // apb slave
  input wire eis_pkg::eis_apb_req_t APB_REQ_I,
  output eis_pkg::eis_apb_rsp_t APB_RSP_O,
  // pins
  input wire logic [7:0] EXTERNAL_IRQ_PIN_I,
  input wire logic NMI_PIN_N_I,
  input wire logic [3:0] KEY_PIN_I,
  // peripheral requests for shared vectors 4 and 5
  input wire logic SERIAL3_REQ_I,
  input wire logic SERIAL4_REQ_I,
  // peripheral pairs for other shared vectors: a when select 0, b when 1; vectors 0 and 1 take b when their select is 1, else nothing
  input wire logic [9:0] PERIPH_A_REQ_I,
  input wire logic [9:0] PERIPH_B_REQ_I,
  // core side
  input wire eis_pkg::eis_cpu_t CPU_I,
  input wire eis_pkg::eis_instr_t INSTR_I,
  input wire logic FETCH_VALID_I,
  input wire logic [19:0] FETCH_ADDR_I,
  // maskable request offered to the core
  output logic IRQ_O,
  output logic [2:0] IRQ_SRC_O,
  output logic [2:0] IRQ_LEVEL_O,
  // special and software interrupts
  output logic NMI_O,
  output logic KEY_IRQ_O,
  output logic ADDR_MATCH_O,
  output logic SW_IRQ_O,
  output eis_pkg::eis_sw_kind_t SW_KIND_O,
  output logic STACK_SELECT_CLEAR_O,
  // routed shared vector requests
  output logic [9:0] SHARED_REQ_O
);
  import eis_pkg::*;

  // all state of the top level
  typedef struct packed {
    logic [7:0] sel_primary;
    logic [7:0] sel_second;
    logic [7:0] sel_third;
    logic nmi_enable_sticky;
    logic [2:0] nmi_filter_setting;
    logic [2:0] port_ctrl;           // key, in7, in6 block
    logic [1:0] addr_match_enable_a;
    logic [1:0] addr_match_enable_b;
    logic [N_AM-1:0][19:0] addr_match_target;
    eis_apb_rsp_t rsp;
    logic irq;
    logic [2:0] src;
    logic [2:0] lvl;
    logic nmi;
    logic key;
    logic am;
    logic sw;
    eis_sw_kind_t kind;
    logic u_clr;
    logic [9:0] shared;
  } eis_top_st_t;

  eis_top_st_t st;
  eis_top_st_t next_st;

  // index decoded from the byte address
  function automatic logic [9:0] addr_index(input logic [11:0] a);
    addr_index = a[11:2];
  endfunction : addr_index

  // true when a word is one of the four match targets
  function automatic logic am_hit(input logic [9:0] idx, input int k);
    am_hit = (idx == IDX_AM_TARGET0 + 10'(4 * k));
  endfunction : am_hit

  // apb phases
  logic access;        // access phase, answer pending
  logic wr_now;        // write takes effect this edge
  logic [9:0] idx;     // register index of the transfer
  assign access = APB_REQ_I.psel & APB_REQ_I.penable;
  assign wr_now = access & APB_REQ_I.pwrite & st.rsp.pready;
  assign idx = addr_index(APB_REQ_I.paddr);

  // synchronised pins
  logic [7:0] ext_rise;
  logic [7:0] ext_fall;
  logic [7:0] ext_lvl;
  logic [5:0] misc_rise;
  logic [5:0] misc_fall;
  logic [5:0] misc_lvl;

  eis_edge #(.W(8)) u_ext_edge (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .pin_i(EXTERNAL_IRQ_PIN_I),
    .rise_o(ext_rise),
    .fall_o(ext_fall),
    .level_o(ext_lvl)
  );

  // nmi pin, key pins, and one spare tied high
  eis_edge #(.W(6)) u_misc_edge (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .pin_i({1'b1, KEY_PIN_I, NMI_PIN_N_I}),
    .rise_o(misc_rise),
    .fall_o(misc_fall),
    .level_o(misc_lvl)
  );

  // per-source set events and control register contents
  logic [7:0] both_edge;
  logic [7:0] ext_set;
  logic [7:0] ctrl_set;
  logic [7:0] ctrl_wr;
  logic [7:0] ctrl_acc;
  logic [7:0][7:0] ctrl_val;

  // both-edge selects for inputs 0..5 and 6,7
  assign both_edge = {st.sel_third[1:0], st.sel_primary[5:0]};

  // qualifying edge per input, with analog blocking of inputs 6 and 7
  always_comb begin
    for (int i = 0; i < N_EXT; i++) begin
      if (both_edge[i]) begin
        ext_set[i] = ext_rise[i] | ext_fall[i];
      end else if (ctrl_val[i][POL_BIT]) begin
        ext_set[i] = ext_rise[i];
      end else begin
        ext_set[i] = ext_fall[i];
      end
    end
    if (st.port_ctrl[0]) begin
      ext_set[6] = 1'b0;
    end
    if (st.port_ctrl[1]) begin
      ext_set[7] = 1'b0;
    end
  end

  // shared vectors 4 and 5 take the serial units unless inputs are selected
  always_comb begin
    ctrl_set = ext_set;
    ctrl_set[4] = st.sel_primary[SHARED_A_BIT] ? ext_set[4] : SERIAL3_REQ_I;
    ctrl_set[5] = st.sel_primary[SHARED_B_BIT] ? ext_set[5] : SERIAL4_REQ_I;
  end

  // control registers for the eight external sources
  for (genvar g = 0; g < N_EXT; g++) begin : g_ctrl
    assign ctrl_wr[g] = wr_now & (idx == IDX_EXT_CTRL[g]);
    assign ctrl_acc[g] = CPU_I.accept & st.irq & (st.src == 3'(g));
    eis_ctrl u_ctrl (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RST_N_I),
      .wr_i(ctrl_wr[g]),
      .wdata_i(APB_REQ_I.pwdata[7:0]),
      .set_i(ctrl_set[g]),
      .accept_i(ctrl_acc[g]),
      .value_o(ctrl_val[g])
    );
  end

  // shared vector select per routed pair
  logic [9:0] route_sel;
  logic [9:0] route_on;
  assign route_sel = {st.sel_second[7:4], st.sel_third[6:3], 2'b11};
  assign route_on = {8'hFF, st.sel_second[3:2]};

  // read data for the addressed register
  logic [31:0] rdata;
  logic rhit;
  always_comb begin
    rdata = '0;
    rhit = 1'b1;
    unique case (idx)
      IDX_MODE: rdata[NMI_EN_BIT] = st.nmi_enable_sticky;
      IDX_SEL_PRIMARY: rdata[7:0] = st.sel_primary;
      IDX_SEL_SECOND: rdata[7:0] = st.sel_second;
      IDX_SEL_THIRD: rdata[7:0] = st.sel_third;
      IDX_AM_EN_A: rdata[1:0] = st.addr_match_enable_a;
      IDX_AM_EN_B: rdata[1:0] = st.addr_match_enable_b;
      IDX_PORT_CTRL: rdata[7:5] = st.port_ctrl;
      IDX_NMI_FILTER: rdata[2:0] = st.nmi_filter_setting;
      default: rhit = 1'b0;
    endcase
    for (int i = 0; i < N_EXT; i++) begin
      if (idx == IDX_EXT_CTRL[i]) begin
        rdata[7:0] = ctrl_val[i];
        rhit = 1'b1;
      end
    end
    for (int k = 0; k < N_AM; k++) begin
      if (am_hit(idx, k)) begin
        rdata[19:0] = st.addr_match_target[k];
        rhit = 1'b1;
      end
    end
  end

  // highest eligible source; ties go to the lower index
  logic cand;
  logic [2:0] cand_src;
  logic [2:0] cand_lvl;
  always_comb begin
    cand = 1'b0;
    cand_src = '0;
    cand_lvl = '0;
    for (int i = 0; i < N_EXT; i++) begin
      if (ctrl_val[i][FLAG_BIT] && ctrl_val[i][LVL_MSB:0] > CPU_I.processor_priority_level &&
          ctrl_val[i][LVL_MSB:0] > cand_lvl) begin
        cand = 1'b1;
        cand_src = 3'(i);
        cand_lvl = ctrl_val[i][LVL_MSB:0];
      end
    end
  end

  // next state: registers, apb answer and all outputs
  always_comb begin
    next_st = st;
    // apb: one wait state, answer on the second access cycle
    next_st.rsp.pready = access & ~st.rsp.pready;
    next_st.rsp.prdata = (access & ~st.rsp.pready) ? rdata : '0;
    next_st.rsp.pslverr = access & ~st.rsp.pready & ~rhit;
    if (wr_now) begin
      unique case (idx)
        IDX_SEL_PRIMARY: next_st.sel_primary = APB_REQ_I.pwdata[7:0];
        IDX_SEL_SECOND: next_st.sel_second = APB_REQ_I.pwdata[7:0];
        IDX_SEL_THIRD: next_st.sel_third = APB_REQ_I.pwdata[7:0];
        IDX_AM_EN_A: next_st.addr_match_enable_a = APB_REQ_I.pwdata[1:0];
        IDX_AM_EN_B: next_st.addr_match_enable_b = APB_REQ_I.pwdata[1:0];
        IDX_PORT_CTRL: next_st.port_ctrl = APB_REQ_I.pwdata[7:5];
        IDX_NMI_FILTER: next_st.nmi_filter_setting = APB_REQ_I.pwdata[2:0];
        // a written 0 leaves the enable set
        IDX_MODE: next_st.nmi_enable_sticky = st.nmi_enable_sticky |
                                              APB_REQ_I.pwdata[NMI_EN_BIT];
        // match targets are written below and control words in g_ctrl; others are refused
        default: ;
      endcase
      for (int k = 0; k < N_AM; k++) begin
        if (am_hit(idx, k)) begin
          next_st.addr_match_target[k] = APB_REQ_I.pwdata[19:0];
        end
      end
    end
    // maskable request offered while enabled and not being accepted
    next_st.irq = cand & CPU_I.iflag & ~(CPU_I.accept & st.irq);
    next_st.src = cand_src;
    next_st.lvl = cand_lvl;
    // nmi on a falling pin once the nmi enable is set, independent of iflag
    next_st.nmi = st.nmi_enable_sticky & misc_fall[0];
    // key inputs fire on a falling key unless blocked
    next_st.key = ~st.port_ctrl[2] & (|misc_fall[4:1]);
    // address match one cycle after the enabled matching fetch
    next_st.am = 1'b0;
    for (int k = 0; k < N_AM; k++) begin
      if (FETCH_VALID_I && FETCH_ADDR_I == st.addr_match_target[k] &&
          (k < 2 ? st.addr_match_enable_a[k % 2] : st.addr_match_enable_b[k % 2])) begin
        next_st.am = 1'b1;
      end
    end
    // software interrupts, undefined and break first
    next_st.sw = 1'b1;
    next_st.u_clr = 1'b0;
    if (INSTR_I.undefined_opcode_instr) begin
      next_st.kind = SW_UND;
    end else if (INSTR_I.break_instr) begin
      next_st.kind = SW_BRK;
    end else if (INSTR_I.overflow_trap_instr && INSTR_I.overflow_flag) begin
      next_st.kind = SW_OVF;
    end else if (INSTR_I.int_instr) begin
      next_st.kind = SW_INT;
      next_st.u_clr = INSTR_I.int_num < INT_NUM_STACK_LIMIT;
    end else begin
      next_st.kind = SW_NONE;
      next_st.sw = 1'b0;
    end
    // routed shared vectors
    for (int v = 0; v < N_SHARED; v++) begin
      next_st.shared[v] = route_on[v] &
                          (route_sel[v] ? PERIPH_B_REQ_I[v] : PERIPH_A_REQ_I[v]);
    end
  end

  // register state
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      st <= '0;
      st.sel_primary <= SEL_RESET;
      st.sel_second <= SEL_RESET;
      st.sel_third <= SEL_RESET;
      st.addr_match_target <= {N_AM{AM_TARGET_RESET}};
      st.kind <= SW_NONE;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign APB_RSP_O = st.rsp;
  assign IRQ_O = st.irq;
  assign IRQ_SRC_O = st.src;
  assign IRQ_LEVEL_O = st.lvl;
  assign NMI_O = st.nmi;
  assign KEY_IRQ_O = st.key;
  assign ADDR_MATCH_O = st.am;
  assign SW_IRQ_O = st.sw;
  assign SW_KIND_O = st.kind;
  assign STACK_SELECT_CLEAR_O = st.u_clr;
  assign SHARED_REQ_O = st.shared;

  // checks
  property p_lvl_nonzero;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I) IRQ_O |-> IRQ_LEVEL_O != 3'b000;
  endproperty
  a_lvl_nonzero: assert property (p_lvl_nonzero) else $error("zero level offered");
  property p_offer_cond;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      IRQ_O |-> $past(CPU_I.iflag) && IRQ_LEVEL_O > $past(CPU_I.processor_priority_level);
  endproperty
  a_offer_cond: assert property (p_offer_cond) else $error("offer not qualified");
  property p_accept_clear;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (CPU_I.accept && IRQ_O && !ctrl_set[IRQ_SRC_O]) |=> !ctrl_val[$past(IRQ_SRC_O)][FLAG_BIT];
  endproperty
  a_accept_clear: assert property (p_accept_clear) else $error("flag kept after accept");
  property p_no_sw_set;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (ctrl_wr[0] && !ctrl_val[0][FLAG_BIT] && !ctrl_set[0]) |=> !ctrl_val[0][FLAG_BIT];
  endproperty
  a_no_sw_set: assert property (p_no_sw_set) else $error("flag set by write");
  property p_edge_sets;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I) ext_set[0] |=> ctrl_val[0][FLAG_BIT];
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("edge lost");
  property p_nmi_sticky;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I) st.nmi_enable_sticky |=> st.nmi_enable_sticky;
  endproperty
  a_nmi_sticky: assert property (p_nmi_sticky) else $error("nmi enable dropped");
  property p_nmi_fall;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (misc_fall[0] && st.nmi_enable_sticky) |=> NMI_O ##1 !NMI_O;
  endproperty
  a_nmi_fall: assert property (p_nmi_fall) else $error("nmi not pulsed");
  property p_in6_block;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I) st.port_ctrl[0] |-> !ext_set[6];
  endproperty
  a_in6_block: assert property (p_in6_block) else $error("blocked input fired");
  property p_overflow;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (INSTR_I.overflow_trap_instr && !INSTR_I.overflow_flag && !INSTR_I.int_instr &&
       !INSTR_I.undefined_opcode_instr && !INSTR_I.break_instr) |=> !SW_IRQ_O;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow trap without flag");
  property p_stack_sel;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      STACK_SELECT_CLEAR_O |-> SW_KIND_O == SW_INT && $past(INSTR_I.int_num) < 6'd32;
  endproperty
  a_stack_sel: assert property (p_stack_sel) else $error("stack clear wrong");
  c_accept: cover property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) IRQ_O && CPU_I.accept);
  c_nmi: cover property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) NMI_O);
  c_am: cover property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) ADDR_MATCH_O);
endmodule : eis_top

/* File: eis_core_model.sv */
// eis_core_model: core acceptance side facing the interrupt front end.
// assumes the offered request stays up until this model accepts it.
`timescale 1ns/100ps
module eis_core_model
  import eis_pkg::*;
(
  // clock
  input wire logic clk_i,
  // offered request, acceptance timing and priority level
  input wire logic irq_i,
  input wire logic [1:0] dly_i,
  input wire logic [2:0] ipl_i,
  // core state and acceptance pulse
  output eis_cpu_t cpu_o
);
  // cycles the current offer has been waiting
  logic [2:0] cnt = 3'h0;
  // accept once, dly_i cycles into each offer
  always_ff @(posedge clk_i) begin
    cnt <= irq_i ? cnt + 3'h1 : 3'h0;
    cpu_o.iflag <= 1'b1;
    cpu_o.processor_priority_level <= ipl_i;
    cpu_o.accept <= irq_i && (cnt == {1'b0, dly_i});
  end
endmodule : eis_core_model

/* File: eis_top_bench.sv */
// eis_top_bench: self-checking bench for the interrupt front end.
// assumes eis_pkg, eis_top and eis_core_model are compiled before it.
`timescale 1ns/100ps
module eis_top_bench;
  import eis_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  eis_apb_req_t req = '0;
  eis_apb_rsp_t rsp;
  logic [7:0] pin = 8'hFF;
  logic nmi_n = 1'b1;
  logic [9:0] pa = '0;
  logic [9:0] pb = '0;
  eis_cpu_t cpu;
  eis_instr_t ins = '0;
  logic [2:0] processor_priority_level = 3'h7;
  logic irq, nmi, swi, stk, key, am;
  logic [3:0] keys = 4'hF;
  logic [3:0] flg;
  logic s3 = 1'b0;
  logic fv = 1'b0;
  logic [2:0] src, lvl;
  eis_sw_kind_t kind;
  logic [9:0] shr, ex;
  logic [31:0] rd, lfsr = 32'h4b67_51ac;
  logic [7:0] sel2, sel3;
  logic er;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  // instruction events and the expected {request, kind, stack clear} of each
  eis_instr_t tv [6] = '{11'h100, 11'h180, 11'h400, 11'h200, 11'h05F, 11'h060};
  logic [4:0] se [6] = '{5'h00, 5'h14, 5'h12, 5'h16, 5'h19, 5'h18};
  // design; fetch address stays at zero, the reset value of match target 0
  eis_top i_eis_top (.SYS_CLK_I(clk), .RST_N_I(rst_n), .APB_REQ_I(req), .APB_RSP_O(rsp),
    .EXTERNAL_IRQ_PIN_I(pin), .NMI_PIN_N_I(nmi_n), .KEY_PIN_I(keys), .SERIAL3_REQ_I(s3),
    .SERIAL4_REQ_I(1'b0), .PERIPH_A_REQ_I(pa), .PERIPH_B_REQ_I(pb), .CPU_I(cpu),
    .INSTR_I(ins), .FETCH_VALID_I(fv), .FETCH_ADDR_I(20'h0_0000), .IRQ_O(irq),
    .IRQ_SRC_O(src), .IRQ_LEVEL_O(lvl), .NMI_O(nmi), .KEY_IRQ_O(key), .ADDR_MATCH_O(am),
    .SW_IRQ_O(swi), .SW_KIND_O(kind), .STACK_SELECT_CLEAR_O(stk), .SHARED_REQ_O(shr));
  // slow core: accepts two cycles into each offer
  eis_core_model i_eis_core_model (.clk_i(clk), .irq_i(irq), .dly_i(2'h2), .ipl_i(processor_priority_level),
    .cpu_o(cpu));
  initial begin
    forever #5 clk = ~clk;
  end
  // step of the random source
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, waits for pready
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, {idx, 2'b00}, {24'h00_0000, wd}};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask : apb
  // bounded wait for a design flag: 0 irq, 1 nmi, 2 key, 3 address match
  assign flg = {am, key, nmi, irq};
  task automatic wfor(input int w);
    for (int k = 0; k < 10 && flg[w] !== 1'b1; k++) @(posedge clk);
  endtask : wfor
  // move one pin, then read back its control register
  task automatic pin_chk(input int n, input logic v, input logic [7:0] exp);
    pin[n] <= v;
    repeat (6) @(posedge clk);
    apb(1'b0, IDX_EXT_CTRL[n], 8'h00);
    chk(rd & 32'h0000_003F, {24'h00_0000, exp});
  endtask : pin_chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // select registers clear after reset
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, IDX_SEL_THIRD + 10'(i), 8'h00);
      chk(rd, {24'h00_0000, SEL_RESET});
    end
    // unmapped place is refused
    apb(1'b0, 10'h000, 8'h00);
    chk({er, rd[30:0]}, 32'h8000_0000);
    // software only clears flags; a level write leaves the flag clear
    apb(1'b1, IDX_EXT_CTRL[0], 8'h05);
    apb(1'b0, IDX_EXT_CTRL[0], 8'h00);
    chk(rd & 32'h0000_003F, 32'h0000_0005);
    // level 5 waits while core sits at 7, then is taken at 3
    pin_chk(0, 1'b0, 8'h0D);
    chk(32'(irq), 32'h0);
    processor_priority_level <= 3'h3;
    wfor(0);
    chk(32'({irq, src, lvl}), 32'h0000_0045);
    repeat (6) @(posedge clk);
    apb(1'b0, IDX_EXT_CTRL[0], 8'h00);
    chk(rd & 32'h0000_003F, 32'h0000_0005);
    processor_priority_level <= 3'h7;
    // rising polarity ignores the fall
    apb(1'b1, IDX_EXT_CTRL[1], 8'h13);
    pin_chk(1, 1'b0, 8'h13);
    pin_chk(1, 1'b1, 8'h1B);
    // both edges on input 2, polarity kept at falling
    apb(1'b1, IDX_SEL_PRIMARY, 8'h04);
    apb(1'b1, IDX_EXT_CTRL[2], 8'h02);
    pin_chk(2, 1'b0, 8'h0A);
    apb(1'b1, IDX_EXT_CTRL[2], 8'h02);
    pin_chk(2, 1'b1, 8'h0A);
    // both edges on input 6, then blocked by port control
    apb(1'b1, IDX_SEL_THIRD, 8'h01);
    apb(1'b1, IDX_EXT_CTRL[6], 8'h00);
    pin_chk(6, 1'b0, 8'h08);
    apb(1'b1, IDX_EXT_CTRL[6], 8'h00);
    apb(1'b1, IDX_PORT_CTRL, 8'h20);
    pin_chk(6, 1'b1, 8'h00);
    // filter set first, then nmi enable stays set, then the pin fall fires
    apb(1'b1, IDX_NMI_FILTER, 8'h05);
    apb(1'b0, IDX_NMI_FILTER, 8'h00);
    chk(rd, 32'h0000_0005);
    apb(1'b1, IDX_MODE, 8'h10);
    apb(1'b1, IDX_MODE, 8'h00);
    apb(1'b0, IDX_MODE, 8'h00);
    chk(32'(rd[NMI_EN_BIT]), 32'h1);
    nmi_n <= 1'b0;
    wfor(1);
    chk(32'(nmi), 32'h1);
    // a falling key fires, and no longer once keys are blocked
    keys <= 4'hB;
    wfor(2);
    chk(32'(key), 32'h1);
    apb(1'b1, IDX_PORT_CTRL, 8'hA0);
    keys <= 4'h9;
    wfor(2);
    chk(32'(key), 32'h0);
    // serial unit 3 sets source 4 while its shared select is 0
    apb(1'b1, IDX_EXT_CTRL[4], 8'h00);
    s3 <= 1'b1;
    @(posedge clk);
    s3 <= 1'b0;
    apb(1'b0, IDX_EXT_CTRL[4], 8'h00);
    chk(rd & 32'h0000_003F, 32'h0000_0008);
    // fetch at the reset match target with its enable set
    apb(1'b1, IDX_AM_EN_A, 8'h01);
    fv <= 1'b1;
    wfor(3);
    chk(32'(am), 32'h1);
    fv <= 1'b0;
    // instruction events, kinds and stack select
    for (int i = 0; i < 6; i++) begin
      ins <= tv[i];
      @(posedge clk);
      ins <= '0;
      @(posedge clk);
      chk(32'({swi, kind, stk}), 32'(se[i]));
    end
    // random routing of shared vectors
    for (int i = 0; i < 4; i++) begin
      lfsr = nx(lfsr);
      sel2 = {lfsr[7:2], 2'b00};
      sel3 = {1'b0, lfsr[14:11], 3'b000};
      apb(1'b1, IDX_SEL_SECOND, sel2);
      apb(1'b1, IDX_SEL_THIRD, sel3);
      pa <= lfsr[25:16];
      pb <= lfsr[31:22];
      repeat (3) @(posedge clk);
      ex[0] = sel2[2] & pb[0];
      ex[1] = sel2[3] & pb[1];
      for (int b = 2; b < 6; b++) ex[b] = sel3[b + 1] ? pb[b] : pa[b];
      for (int b = 6; b < 10; b++) ex[b] = sel2[b - 2] ? pb[b] : pa[b];
      chk(32'(shr), 32'(ex));
    end
    end_sim();
  end
endmodule : eis_top_bench
